// ---- hw/led_dim_pkg.sv ----
// shared constants, register map and state types of the led dimming controller
package led_dim_pkg;

	// ----------------------------------------
	// clock and timing
	// ----------------------------------------
	localparam real CLK_FREQ_MHZ = 40.0;
	localparam real EN_OFF_TIME_MS = 30.0;
	localparam real EXT_LOW_TIME_MS = 30.5;
	localparam real GLITCH_MIN_US = 0.15;
	localparam real GLITCH_MAX_US = 0.45;
	localparam int EN_OFF_CYCLES = int'($ceil(EN_OFF_TIME_MS * 1000.0 * CLK_FREQ_MHZ));
	localparam int EXT_LOW_CYCLES = int'($ceil(EXT_LOW_TIME_MS * 1000.0 * CLK_FREQ_MHZ));
	localparam int GLITCH_MIN_CYCLES = int'($ceil(GLITCH_MIN_US * CLK_FREQ_MHZ));
	localparam int GLITCH_MAX_CYCLES = int'($floor(GLITCH_MAX_US * CLK_FREQ_MHZ));
	localparam int GLITCH_CYCLES = (GLITCH_MIN_CYCLES + GLITCH_MAX_CYCLES) / 2;
	localparam logic [4:0] STRAP_WAIT = 5'h1F;

	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [7:0] REG_BRIGHTNESS_DUTY = 8'h00;
	localparam logic [7:0] REG_DIMMING_MODE = 8'h01;
	localparam logic [7:0] REG_DC_CURRENT = 8'h07;
	localparam logic [7:0] BRIGHTNESS_RESET = 8'hFF;
	localparam logic [7:0] DIMMING_MODE_RESET = 8'h01;
	localparam logic [7:0] DC_CURRENT_RESET = 8'hFF;
	localparam logic [7:0] MODE_PRODUCT = 8'h01;
	localparam logic [7:0] MODE_EXTERNAL = 8'h03;
	localparam logic [7:0] MODE_INTERNAL = 8'h05;

	// ----------------------------------------
	// dimming waveform
	// ----------------------------------------
	localparam logic [7:0] DUTY_LAST_PHASE = 8'hFE;
	localparam logic [7:0] DUTY_FULL = 8'hFF;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] DIV_BITS = 4'h8;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_ADDR = 4'h1,
		ST_ACK_ADDR = 4'h2,
		ST_REG = 4'h3,
		ST_ACK_REG = 4'h4,
		ST_WDATA = 4'h5,
		ST_ACK_DATA = 4'h6,
		ST_RDATA = 4'h7,
		ST_RACK = 4'h8
	} busState_e;

	typedef struct packed {
		logic [7:0] brightness;
		logic [7:0] mode;
		logic [7:0] dcLevel;
	} regFile_s;

	typedef struct packed {
		logic sync1;
		logic sync2;
		logic level;
		logic [4:0] cnt;
	} glitch_s;

	typedef struct packed {
		logic prev;
		logic [15:0] highCnt;
		logic [15:0] totCnt;
		logic [15:0] divisor;
		logic [16:0] rem;
		logic [7:0] quot;
		logic [3:0] bitIdx;
		logic [7:0] duty;
	} meter_s;

	typedef struct packed {
		logic enS1;
		logic enS2;
		logic extS1;
		logic extS2;
		logic fpS1;
		logic fpS2;
		logic [23:0] enLowCnt;
		logic [23:0] extLowCnt;
		logic shutEn;
		logic shutExt;
		logic [4:0] strapCnt;
		logic directMode;
		logic extOnly;
		regFile_s regs;
		busState_e st;
		logic sclPrev;
		logic sdaPrev;
		logic [3:0] bitCnt;
		logic [7:0] shift;
		logic [7:0] regPtr;
		logic isRead;
		logic ackOk;
		logic driveN;
		logic [15:0] stepCnt;
		logic [7:0] phase;
		logic [5:0] chOn;
	} ctrl_s;

endpackage : led_dim_pkg

// ---- hw/glitch_filter.sv ----
// two-flop synchroniser followed by a pulse width suppressor for one serial bus line
`timescale 1ns/1ps
module glitch_filter
	import led_dim_pkg::*;
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic pinIn,
	output logic level
);

	glitch_s s_q;
	glitch_s s_d;

	// ----------------------------------------
	// filter
	// ----------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.sync1 = pinIn;
		s_d.sync2 = s_q.sync1;
		if (s_q.sync2 == s_q.level) begin
			s_d.cnt = 5'h00;
		end else if (s_q.cnt == 5'(GLITCH_CYCLES - 1)) begin
			s_d.level = s_q.sync2; // RULE3
			s_d.cnt = 5'h00;
		end else begin
			s_d.cnt = s_q.cnt + 5'h01;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			s_q <= '0;
			s_q.sync1 <= 1'b1;
			s_q.sync2 <= 1'b1;
			s_q.level <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign level = s_q.level;

	a_glitch_width: assert property (@(posedge sys_clk) disable iff (!nrst) // RULE3
		$changed(s_q.level) |-> $past(s_q.cnt) == 5'(GLITCH_CYCLES - 1) && $past(s_q.sync2) == s_q.level)
		else $error("filtered line moved before the suppression window ran out");

endmodule : glitch_filter

// ---- hw/duty_meter.sv ----
// measures the duty of the external dimming input and digitises it to eight bits
`timescale 1ns/1ps
module duty_meter
	import led_dim_pkg::*;
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic extLevel,
	output logic [7:0] duty
);

	meter_s s_q;
	meter_s s_d;

	// ----------------------------------------
	// period capture and serial division
	// ----------------------------------------
	always_comb begin
		logic [16:0] rem2;
		rem2 = 17'h00000;
		s_d = s_q;
		s_d.prev = extLevel;
		if (s_q.bitIdx != 4'h0) begin
			// restoring division: quotient = high * 256 / period
			rem2 = {s_q.rem[15:0], 1'b0};
			if (rem2 >= {1'b0, s_q.divisor}) begin
				s_d.rem = rem2 - {1'b0, s_q.divisor};
				s_d.quot = {s_q.quot[6:0], 1'b1};
			end else begin
				s_d.rem = rem2;
				s_d.quot = {s_q.quot[6:0], 1'b0};
			end
			s_d.bitIdx = s_q.bitIdx - 4'h1;
			if (s_q.bitIdx == 4'h1) begin
				s_d.duty = s_d.quot; // RULE18
			end
		end
		if (extLevel && !s_q.prev) begin
			if (s_q.totCnt != 16'h0000) begin
				s_d.divisor = s_q.totCnt;
				s_d.rem = {1'b0, s_q.highCnt};
				s_d.quot = 8'h00;
				if (s_q.highCnt >= s_q.totCnt) begin
					s_d.duty = DUTY_FULL;
					s_d.bitIdx = 4'h0;
				end else begin
					s_d.bitIdx = DIV_BITS;
				end
			end
			s_d.highCnt = 16'h0001;
			s_d.totCnt = 16'h0001;
		end else if (s_q.totCnt == 16'hFFFF) begin
			// input held at one level: duty is full or nothing
			s_d.duty = extLevel ? DUTY_FULL : 8'h00; // RULE12
			s_d.bitIdx = 4'h0;
		end else begin
			s_d.totCnt = s_q.totCnt + 16'h0001;
			s_d.highCnt = s_q.highCnt + {15'h0000, extLevel};
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			s_q <= '0;
			s_q.duty <= DUTY_FULL;
		end else begin
			s_q <= s_d;
		end
	end

	assign duty = s_q.duty;

	a_stuck_high: assert property (@(posedge sys_clk) disable iff (!nrst) // RULE12
		(s_q.totCnt == 16'hFFFF && extLevel && s_q.prev) |=> duty == DUTY_FULL)
		else $error("input held high did not read as full duty");

endmodule : duty_meter

// ---- hw/led_dimming_pwm_control.sv ----
// serial register slave, enable and input timeouts, and dimming waveform for six led channels
// Operation
// RULE1: enable low over 30 ms shuts down
// RULE2: host waits 2 ms after enable
// RULE3: serial line glitches below window ignored
// RULE4: current code 0..255, resets to 0xFF
// RULE5: current code changes apply immediately
// RULE6: current code zero turns channels off
// RULE7: internal duty has 256 steps
// RULE8: brightness register at 0x00, resets 0xFF
// RULE9: brightness zero turns channels off
// RULE10: internal on fraction equals code over 255
// RULE11: mode 0x05 uses brightness only
// RULE12: mode resets dimming_mode_select; high input follows brightness
// RULE13: product mode multiplies input and brightness
// RULE14: direct mode follows input exactly
// RULE15: all six channels share one waveform
// RULE16: on phase sinks coded current, off none
// RULE17: period from frequency setting outside direct
// RULE18: product uses upper byte of 8x8
// RULE19: input low over 30.5 ms shuts down
// RULE20: mode 0x03 uses external duty only
// RULE21: grounded bus plus tied pin selects direct
// RULE22: period is step count times 255 steps
`timescale 1ns/1ps
module led_dimming_pwm_control
	import led_dim_pkg::*;
#(
	parameter int EnOffCycles = EN_OFF_CYCLES,
	parameter int ExtLowCycles = EXT_LOW_CYCLES,
	// bus address value is arbitrary
	parameter logic [6:0] DevAddr = 7'h2C
)(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic enablePin,
	input wire logic externalDutyInput,
	input wire logic dimmingFreqSetPin,
	input wire logic [15:0] stepCycles,
	input wire logic serialClockLine,
	input wire logic serialDataIn,
	output logic serialDataOut,
	output logic serialDataDriveN,
	output logic [5:0] channelOn,
	output logic [7:0] dcCurrentCode,
	output logic deviceShutdown
);

	ctrl_s s_q;
	ctrl_s s_d;
	logic sclF;
	logic sdaF;
	logic [7:0] extDuty;
	logic shutdown;
	logic stepDone;
	logic wrEn;

	// ----------------------------------------
	// register access
	// ----------------------------------------
	function automatic logic [7:0] regRead(input regFile_s r, input logic [7:0] ptr);
		logic [7:0] v;
		v = 8'h00;
		if (ptr == REG_BRIGHTNESS_DUTY) v = r.brightness;
		else if (ptr == REG_DIMMING_MODE) v = r.mode;
		else if (ptr == REG_DC_CURRENT) v = r.dcLevel;
		return v;
	endfunction : regRead

	function automatic regFile_s regWrite(input regFile_s r, input logic [7:0] ptr, input logic [7:0] v);
		regFile_s n;
		n = r;
		if (ptr == REG_BRIGHTNESS_DUTY) n.brightness = v; // RULE8
		else if (ptr == REG_DIMMING_MODE) n.mode = v;
		else if (ptr == REG_DC_CURRENT) n.dcLevel = v; // RULE4
		return n;
	endfunction : regWrite

	function automatic logic [7:0] productLevel(input logic [7:0] brightness_duty_level, input logic [7:0] dty);
		logic [15:0] p;
		p = {8'h00, brightness_duty_level} * {8'h00, dty};
		// a permanently high input leaves the brightness code untouched
		return (dty == DUTY_FULL) ? brightness_duty_level : p[15:8];
	endfunction : productLevel

	// ----------------------------------------
	// line conditioning
	// ----------------------------------------
	glitch_filter sclFilter (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.pinIn(serialClockLine),
		.level(sclF)
	);

	glitch_filter sdaFilter (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.pinIn(serialDataIn),
		.level(sdaF)
	);

	duty_meter extMeter (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.extLevel(s_q.extS2),
		.duty(extDuty)
	);

	assign shutdown = s_q.shutEn | s_q.shutExt;
	assign stepDone = ({1'b0, s_q.stepCnt} + 17'h00001) >= {1'b0, stepCycles};

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		logic sclRise;
		logic sclFall;
		logic startCond;
		logic stopCond;
		logic usesExt;
		logic pwmOn;
		logic [7:0] level;
		logic [7:0] rd;
		sclRise = sclF & ~s_q.sclPrev;
		sclFall = ~sclF & s_q.sclPrev;
		startCond = sclF & s_q.sclPrev & s_q.sdaPrev & ~sdaF;
		stopCond = sclF & s_q.sclPrev & ~s_q.sdaPrev & sdaF;
		usesExt = 1'b0;
		pwmOn = 1'b0;
		level = 8'h00;
		rd = regRead(s_q.regs, s_q.regPtr);
		wrEn = 1'b0;
		s_d = s_q;
		s_d.enS1 = enablePin;
		s_d.enS2 = s_q.enS1;
		s_d.extS1 = externalDutyInput;
		s_d.extS2 = s_q.extS1;
		s_d.fpS1 = dimmingFreqSetPin;
		s_d.fpS2 = s_q.fpS1;
		s_d.sclPrev = sclF;
		s_d.sdaPrev = sdaF;

		// strap sampling once the filtered lines have settled
		if (s_q.strapCnt != STRAP_WAIT) begin
			s_d.strapCnt = s_q.strapCnt + 5'h01;
			if (s_d.strapCnt == STRAP_WAIT) begin
				s_d.directMode = s_q.fpS2 & ~sclF & ~sdaF; // RULE21
				s_d.extOnly = ~s_q.fpS2 & ~sclF & ~sdaF; // RULE20
			end
		end

		// enable low timeout
		if (s_q.enS2) begin
			s_d.enLowCnt = 24'h000000;
			s_d.shutEn = 1'b0;
		end else if (s_q.enLowCnt == 24'(EnOffCycles - 1)) begin
			s_d.shutEn = 1'b1; // RULE1
		end else begin
			s_d.enLowCnt = s_q.enLowCnt + 24'h000001;
		end

		// external input low timeout in the modes that read it
		usesExt = s_q.directMode | s_q.extOnly | (s_q.regs.mode != MODE_INTERNAL);
		if (s_q.extS2 || !usesExt) begin
			s_d.extLowCnt = 24'h000000;
			s_d.shutExt = 1'b0;
		end else if (s_q.extLowCnt == 24'(ExtLowCycles - 1)) begin
			s_d.shutExt = 1'b1; // RULE19
		end else begin
			s_d.extLowCnt = s_q.extLowCnt + 24'h000001;
		end

		// serial register slave
		if (startCond) begin
			s_d.st = ST_ADDR;
			s_d.bitCnt = 4'h0;
			s_d.driveN = 1'b1;
		end else if (stopCond) begin
			s_d.st = ST_IDLE;
			s_d.driveN = 1'b1;
		end else if (sclRise) begin
			unique case (s_q.st)
				ST_ADDR, ST_REG, ST_WDATA: begin
					s_d.shift = {s_q.shift[6:0], sdaF};
					s_d.bitCnt = s_q.bitCnt + 4'h1;
				end
				ST_RACK: begin
					s_d.ackOk = ~sdaF;
				end
				default: begin
				end
			endcase
		end else if (sclFall) begin
			unique case (s_q.st)
				ST_ADDR: begin
					if (s_q.bitCnt == BYTE_BITS) begin
						if (s_q.shift[7:1] == DevAddr) begin
							s_d.st = ST_ACK_ADDR;
							s_d.isRead = s_q.shift[0];
							s_d.driveN = 1'b0;
						end else begin
							s_d.st = ST_IDLE;
						end
					end
				end
				ST_REG: begin
					if (s_q.bitCnt == BYTE_BITS) begin
						s_d.regPtr = s_q.shift;
						s_d.st = ST_ACK_REG;
						s_d.driveN = 1'b0;
					end
				end
				ST_WDATA: begin
					if (s_q.bitCnt == BYTE_BITS) begin
						wrEn = 1'b1;
						s_d.regs = regWrite(s_q.regs, s_q.regPtr, s_q.shift); // RULE5
						s_d.regPtr = s_q.regPtr + 8'h01;
						s_d.st = ST_ACK_DATA;
						s_d.driveN = 1'b0;
					end
				end
				ST_ACK_ADDR: begin
					s_d.bitCnt = 4'h0;
					if (s_q.isRead) begin
						s_d.shift = rd;
						s_d.driveN = rd[7];
						s_d.regPtr = s_q.regPtr + 8'h01;
						s_d.bitCnt = 4'h1;
						s_d.st = ST_RDATA;
					end else begin
						s_d.driveN = 1'b1;
						s_d.st = ST_REG;
					end
				end
				ST_ACK_REG, ST_ACK_DATA: begin
					s_d.bitCnt = 4'h0;
					s_d.driveN = 1'b1;
					s_d.st = ST_WDATA;
				end
				ST_RDATA: begin
					if (s_q.bitCnt == BYTE_BITS) begin
						s_d.driveN = 1'b1;
						s_d.st = ST_RACK;
					end else begin
						s_d.shift = {s_q.shift[6:0], 1'b0};
						s_d.driveN = s_q.shift[6];
						s_d.bitCnt = s_q.bitCnt + 4'h1;
					end
				end
				ST_RACK: begin
					if (s_q.ackOk) begin
						s_d.shift = rd;
						s_d.driveN = rd[7];
						s_d.regPtr = s_q.regPtr + 8'h01;
						s_d.bitCnt = 4'h1;
						s_d.st = ST_RDATA;
					end else begin
						s_d.st = ST_IDLE;
					end
				end
				default: begin
				end
			endcase
		end

		// enable timeout shutdown drops the bus and restores register defaults
		if (s_q.shutEn) begin
			s_d.st = ST_IDLE;
			s_d.driveN = 1'b1;
			s_d.regs = '{brightness: BRIGHTNESS_RESET, mode: DIMMING_MODE_RESET, dcLevel: DC_CURRENT_RESET}; // RULE1
		end

		// dimming period: 255 steps of stepCycles clocks each
		if (stepDone) begin
			s_d.stepCnt = 16'h0000;
			s_d.phase = (s_q.phase == DUTY_LAST_PHASE) ? 8'h00 : s_q.phase + 8'h01; // RULE22 RULE17
		end else begin
			s_d.stepCnt = s_q.stepCnt + 16'h0001;
		end

		// waveform source
		if (s_q.extOnly || s_q.regs.mode == MODE_EXTERNAL) begin
			level = extDuty; // RULE20
		end else if (s_q.regs.mode == MODE_INTERNAL) begin
			level = s_q.regs.brightness; // RULE11
		end else begin
			level = productLevel(s_q.regs.brightness, extDuty); // RULE13 RULE18 RULE12
		end
		if (s_q.directMode) begin
			pwmOn = s_q.extS2; // RULE14
		end else begin
			pwmOn = s_q.phase < level; // RULE7 RULE10 RULE9
		end
		s_d.chOn = {6{pwmOn && s_q.regs.dcLevel != 8'h00 && !shutdown}}; // RULE15 RULE16 RULE6
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			s_q <= '0;
			s_q.enS1 <= 1'b1;
			s_q.enS2 <= 1'b1;
			s_q.regs.brightness <= BRIGHTNESS_RESET;
			s_q.regs.mode <= DIMMING_MODE_RESET;
			s_q.regs.dcLevel <= DC_CURRENT_RESET;
			s_q.st <= ST_IDLE;
			s_q.sclPrev <= 1'b1;
			s_q.sdaPrev <= 1'b1;
			s_q.driveN <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign serialDataOut = 1'b0;
	assign serialDataDriveN = s_q.driveN;
	assign channelOn = s_q.chOn;
	assign dcCurrentCode = s_q.regs.dcLevel; // RULE16
	assign deviceShutdown = shutdown;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	sequence internalOnly;
		!s_q.directMode && !s_q.extOnly && s_q.regs.mode == MODE_INTERNAL;
	endsequence

	sequence lastStep;
		s_q.phase == DUTY_LAST_PHASE && stepDone;
	endsequence

	a_en_timeout: assert property ($rose(s_q.shutEn) |-> $past(s_q.enLowCnt) == 24'(EnOffCycles - 1)) // RULE1
		else $error("shutdown without the full enable low time");
	a_en_short_low: assert property ((s_q.enS2 && !s_q.shutEn) |=> !s_q.shutEn) // RULE1
		else $error("shutdown while enable was high");
	a_ext_timeout: assert property ($rose(s_q.shutExt) |-> $past(s_q.extLowCnt) == 24'(ExtLowCycles - 1)) // RULE19
		else $error("input low shutdown at the wrong count");
	a_dc_zero_off: assert property (s_q.regs.dcLevel == 8'h00 |=> channelOn == 6'h00) // RULE6
		else $error("channels on with zero current code");
	a_dc_on_fly: assert property ((wrEn && s_q.regPtr == REG_DC_CURRENT && !s_q.shutEn) // RULE5
		|=> dcCurrentCode == $past(s_q.shift))
		else $error("current code write not applied next cycle");
	a_brt_zero_off: assert property ((internalOnly and s_q.regs.brightness == 8'h00) |=> channelOn == 6'h00) // RULE9
		else $error("channels on with zero brightness");
	a_internal_duty: assert property ((internalOnly and !shutdown && s_q.regs.dcLevel != 8'h00) // RULE10
		|=> channelOn == {6{$past(s_q.phase) < $past(s_q.regs.brightness)}})
		else $error("internal duty does not follow brightness");
	a_direct_follow: assert property ((s_q.directMode && !shutdown && s_q.regs.dcLevel != 8'h00) // RULE14
		|=> channelOn == {6{$past(s_q.extS2)}})
		else $error("direct mode does not follow the input");
	a_channels_grouped: assert property (channelOn == 6'h00 || channelOn == 6'h3F) // RULE15
		else $error("channels switched apart");
	a_phase_wrap: assert property (lastStep |=> s_q.phase == 8'h00 ##1 s_q.phase <= 8'h01) // RULE22
		else $error("dimming period did not wrap after 255 steps");

endmodule : led_dimming_pwm_control

// ---- test/bus_host_model.sv ----
// bus host and external dimming source on the far side of the controller
`timescale 1ns/1ps
module bus_host_model (
	input wire logic sys_clk,
	input wire logic devDriveN,
	output logic scl,
	output logic sdaWire,
	output logic extPwm
);
	logic sdaHost = 1'b1;
	logic glitchEn = 1'b0;
	int extHighNs = 1;
	int extLowNs = 0;
	initial scl = 1'b1;
	// open drain: either party pulls low, pull-up otherwise
	assign sdaWire = sdaHost & devDriveN;
	// ----------------------------------------
	// external dimming source, free of the clock phase
	// ----------------------------------------
	always begin
		extPwm = (extHighNs != 0);
		#((extHighNs > 0 && extLowNs > 0) ? extHighNs : 100);
		if (extHighNs > 0 && extLowNs > 0) begin
			extPwm = 1'b0;
			#(extLowNs);
		end
	end
	// ----------------------------------------
	// bus bit timing: 64 clocks low, 36 high
	// ----------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : tick
	task automatic bit_out(input logic b);
		tick(20);
		sdaHost = b;
		tick(10);
		scl = glitchEn;
		tick(6);
		scl = 1'b0;
		tick(28);
		scl = 1'b1;
		tick(36);
		scl = 1'b0;
	endtask : bit_out
	task automatic bit_in(output logic b);
		tick(20);
		sdaHost = 1'b1;
		tick(44);
		scl = 1'b1;
		tick(18);
		b = sdaWire;
		tick(18);
		scl = 1'b0;
	endtask : bit_in
	task automatic start();
		tick(20);
		sdaHost = 1'b1;
		tick(44);
		scl = 1'b1;
		tick(40);
		sdaHost = 1'b0;
		tick(40);
		scl = 1'b0;
	endtask : start
	task automatic stop();
		tick(20);
		sdaHost = 1'b0;
		tick(44);
		scl = 1'b1;
		tick(40);
		sdaHost = 1'b1;
		tick(60);
	endtask : stop
	task automatic send(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) bit_out(b[i]);
		bit_in(ack);
	endtask : send
	task automatic recv(input logic last, output logic [7:0] b);
		for (int i = 7; i >= 0; i--) bit_in(b[i]);
		bit_out(last);
	endtask : recv
	task automatic ground();
		sdaHost = 1'b0;
		scl = 1'b0;
	endtask : ground
endmodule : bus_host_model

// ---- test/led_dimming_pwm_control_test.sv ----
// self-checking bench for the led dimming controller
`timescale 1ns/1ps
module led_dimming_pwm_control_test;
	import led_dim_pkg::*;
	localparam int STEP = 2;
	localparam int PERIOD = 255 * STEP;
	localparam int HOST_WAIT = 80000;
	localparam logic [6:0] ADDR = 7'h2C;
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic enablePin = 1'b1;
	logic dimmingFreqSetPin = 1'b0;
	logic scl, sdaWire, extPwm, serialDataOut, serialDataDriveN, deviceShutdown, ack, prev;
	logic [5:0] channelOn;
	logic [7:0] dcCurrentCode;
	logic [7:0] rd [3];
	logic [7:0] brts [4] = '{8'h00, 8'h01, 8'hFE, 8'hFF};
	int num_errors = 0;
	int n_tests = 0;
	int onCnt, rises;
	always #12.5 sys_clk = ~sys_clk;
	led_dimming_pwm_control #(.EnOffCycles(200), .ExtLowCycles(250), .DevAddr(ADDR)) led_dimming_pwm_control_inst (
		.sys_clk(sys_clk), .nrst(nrst), .enablePin(enablePin), .externalDutyInput(extPwm),
		.dimmingFreqSetPin(dimmingFreqSetPin), .stepCycles(16'h0002), .serialClockLine(scl),
		.serialDataIn(sdaWire), .serialDataOut(serialDataOut), .serialDataDriveN(serialDataDriveN),
		.channelOn(channelOn), .dcCurrentCode(dcCurrentCode), .deviceShutdown(deviceShutdown));
	bus_host_model host (.sys_clk(sys_clk), .devDriveN(serialDataDriveN), .scl(scl), .sdaWire(sdaWire),
		.extPwm(extPwm));
	// ----------------------------------------
	// compares and access tasks
	// ----------------------------------------
	task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: value %h, expected %h", $time, got, exp);
		end
	endtask : check_val
	task automatic check_bit(input logic got, input logic exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: flag %b, expected %b", $time, got, exp);
		end
	endtask : check_bit
	task automatic check_cnt(input int got, input int exp, input int tol);
		n_tests++;
		if (got < exp - tol || got > exp + tol) begin
			num_errors++;
			$display("Error at %0t: count %0d, expected %0d", $time, got, exp);
		end
	endtask : check_cnt
	task automatic reg_write(input logic [7:0] off, input logic [7:0] d0, input logic [7:0] d1, input int n);
		host.start();
		host.send({ADDR, 1'b0}, ack);
		check_bit(ack, 1'b0);
		host.send(off, ack);
		check_bit(ack, 1'b0);
		host.send(d0, ack);
		check_bit(ack, 1'b0);
		if (n > 1) host.send(d1, ack);
		host.stop();
	endtask : reg_write
	task automatic reg_read(input logic [7:0] off, input int n);
		host.start();
		host.send({ADDR, 1'b0}, ack);
		host.send(off, ack);
		host.start();
		host.send({ADDR, 1'b1}, ack);
		check_bit(ack, 1'b0);
		for (int i = 0; i < n; i++) host.recv(i == n - 1, rd[i]);
		host.stop();
	endtask : reg_read
	// settle one period, then count on cycles and rising edges over exactly one period
	task automatic measure();
		repeat (PERIOD) @(posedge sys_clk);
		#1;
		onCnt = 0;
		rises = 0;
		prev = channelOn[0];
		repeat (PERIOD) begin
			@(posedge sys_clk);
			#1;
			check_bit(channelOn == {6{channelOn[0]}}, 1'b1);
			onCnt += channelOn[0];
			rises += (channelOn[0] & ~prev);
			prev = channelOn[0];
		end
	endtask : measure
	task automatic wrap_up();
		$display("comparisons %0d, mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : wrap_up
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		repeat (12) @(posedge sys_clk);
		#1 nrst = 1'b1;
		repeat (HOST_WAIT) @(posedge sys_clk);
		#1;
		reg_read(8'h00, 3);
		check_val(rd[0], 8'hFF);
		check_val(rd[1], 8'h01);
		check_val(rd[2], 8'h00);
		check_val(dcCurrentCode, 8'hFF);
		check_bit(serialDataOut, 1'b0);
		host.start();
		host.send({7'h2D, 1'b0}, ack);
		check_bit(ack, 1'b1);
		host.stop();
		reg_write(8'h00, 8'h80, 8'h00, 1);
		measure();
		check_cnt(onCnt, 8'h80 * STEP, 0);
		$display("test reset and default mode done");
		host.glitchEn = 1'b1;
		reg_write(8'h07, 8'h40, 8'h00, 1);
		host.glitchEn = 1'b0;
		check_val(dcCurrentCode, 8'h40);
		reg_read(8'h07, 1);
		check_val(rd[0], 8'h40);
		measure();
		check_cnt(onCnt, 8'h80 * STEP, 0);
		reg_write(8'h07, 8'h00, 8'h00, 1);
		measure();
		check_cnt(onCnt, 0, 0);
		reg_write(8'h07, 8'h40, 8'h00, 1);
		$display("test current code done");
		reg_write(8'h00, 8'h00, 8'h05, 2);
		host.extHighNs = 0;
		foreach (brts[i]) begin
			reg_write(8'h00, brts[i], 8'h00, 1);
			measure();
			check_cnt(onCnt, brts[i] * STEP, 0);
			check_bit(deviceShutdown, 1'b0);
		end
		$display("test internal mode done");
		host.extHighNs = 3200;
		host.extLowNs = 3200;
		reg_write(8'h00, 8'hC0, 8'h01, 2);
		measure();
		check_cnt(onCnt, 8'h60 * STEP, 4);
		check_cnt(rises, 1, 0);
		reg_write(8'h01, 8'h03, 8'h00, 1);
		measure();
		check_cnt(onCnt, 8'h80 * STEP, 4);
		check_cnt(rises, 1, 0);
		$display("test external modes done");
		host.extLowNs = 0;
		enablePin = 1'b0;
		repeat (150) @(posedge sys_clk);
		#1 enablePin = 1'b1;
		check_bit(deviceShutdown, 1'b0);
		check_val(dcCurrentCode, 8'h40);
		// a short high must restart the low-time count
		repeat (5) @(posedge sys_clk);
		#1 enablePin = 1'b0;
		repeat (150) @(posedge sys_clk);
		#1 check_bit(deviceShutdown, 1'b0);
		repeat (110) @(posedge sys_clk);
		#1;
		check_bit(deviceShutdown, 1'b1);
		check_bit(|channelOn, 1'b0);
		check_val(dcCurrentCode, 8'hFF);
		enablePin = 1'b1;
		repeat (5) @(posedge sys_clk);
		#1 check_bit(deviceShutdown, 1'b0);
		host.extHighNs = 0;
		host.extLowNs = 1;
		repeat (300) @(posedge sys_clk);
		#1 check_bit(deviceShutdown, 1'b1);
		check_bit(|channelOn, 1'b0);
		host.extHighNs = 1;
		host.extLowNs = 0;
		repeat (10) @(posedge sys_clk);
		#1 check_bit(deviceShutdown, 1'b0);
		$display("test shutdown done");
		host.ground();
		dimmingFreqSetPin = 1'b1;
		host.extHighNs = 1250;
		host.extLowNs = 3750;
		nrst = 1'b0;
		repeat (2) @(posedge sys_clk);
		#1 nrst = 1'b1;
		repeat (400) @(posedge sys_clk);
		repeat (3) begin
			@(posedge extPwm);
			repeat (5) @(posedge sys_clk);
			#1 check_bit(&channelOn, 1'b1);
			@(negedge extPwm);
			repeat (5) @(posedge sys_clk);
			#1 check_bit(|channelOn, 1'b0);
		end
		$display("test direct mode done");
		// grounded bus with the frequency pin low selects external-only duty
		dimmingFreqSetPin = 1'b0;
		host.extHighNs = 3200;
		host.extLowNs = 3200;
		nrst = 1'b0;
		repeat (2) @(posedge sys_clk);
		#1 nrst = 1'b1;
		repeat (400) @(posedge sys_clk);
		#1;
		measure();
		check_cnt(onCnt, 8'h80 * STEP, 1);
		check_cnt(rises, 1, 0);
		check_bit(deviceShutdown, 1'b0);
		$display("test strap external mode done");
		wrap_up();
	end
	initial begin
		#5000000;
		num_errors++;
		wrap_up();
	end
endmodule : led_dimming_pwm_control_test
